// file: ser_consts.svh
/*
  Register indices, field widths and preset values for the status event
  reporting block. Assumes inclusion by bare name from design files.
*/
`ifndef SER_CONSTS_SVH
`define SER_CONSTS_SVH

`define SER_W            15
`define SER_MAX          15'h7FFF
`define SER_RISE_PRESET  15'h7FFF
`define SER_FALL_PRESET  15'h0000
`define SER_ENA_PRESET   15'h0000
`define SER_ZERO         15'h0000

`define SER_IDX_OP_COND   4'h0
`define SER_IDX_OP_ENA    4'h1
`define SER_IDX_OP_EVT    4'h2
`define SER_IDX_OP_FALL   4'h3
`define SER_IDX_OP_RISE   4'h4
`define SER_IDX_QU_COND   4'h5
`define SER_IDX_QU_ENA    4'h6
`define SER_IDX_QU_EVT    4'h7
`define SER_IDX_QU_FALL   4'h8
`define SER_IDX_QU_RISE   4'h9

`endif

// file: ser_pkg.sv
/*
  Types for the status event reporting block.
  Assumes ser_consts.svh supplies the widths.
*/
`include "ser_consts.svh"

package ser_pkg;
  typedef logic [`SER_W-1:0] ser_word_t;
  typedef logic [3:0]        ser_idx_t;
endpackage

// file: ser_status_asserts.sv
/*
  Port checker for the status register groups.
  Assumes a bind from the bench top and synchronous inputs.
*/
`timescale 1ns/1ps
`include "ser_consts.svh"
module ser_status_asserts (
  input wire logic               i_clk_sys,
  input wire logic               i_rst_n,
  input wire logic               i_inst_reset,
  input wire logic               i_preset,
  input wire ser_pkg::ser_word_t i_op_activity,
  input wire ser_pkg::ser_word_t i_qu_activity,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire ser_pkg::ser_idx_t  i_idx,
  input wire ser_pkg::ser_word_t i_wdata,
  input wire logic [`SER_W-1:0]  o_rdata,
  input wire logic               o_rvalid,
  input wire logic               o_op_summary,
  input wire logic               o_qu_summary,
  input wire logic               o_srq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Enables are cleared on the first edge, summaries follow one edge later
  sequence sums_quiet;
    ##1 !o_op_summary && !o_qu_summary;
  endsequence
  a_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read not answered");
  a_no_stray: assert property (!i_rd |=> !o_rvalid)
    else $error("answer without read");
  a_data_holds: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved");
  a_op_cond: assert property (i_rd && i_idx == 4'h0 && $past(i_rst_n)
    && $stable(i_op_activity) |=> o_rdata == $past(i_op_activity)) else $error("op cond");
  a_qu_cond: assert property (i_rd && i_idx == 4'h5 && $past(i_rst_n)
    && $stable(i_qu_activity) |=> o_rdata == $past(i_qu_activity)) else $error("qu cond");
  a_unmapped_zero: assert property (i_rd && i_idx > 4'h9 |=> o_rdata == `SER_ZERO)
    else $error("unmapped read not zero");
  a_srq_join: assert property (o_srq == (o_op_summary | o_qu_summary))
    else $error("service request mismatch");
  a_preset_mask: assert property (i_preset |=> sums_quiet)
    else $error("summary after preset");
  // Two quiet cycles, so no event or enable change is still in flight
  a_inst_keeps: assert property (i_inst_reset && !i_rd && !i_wr && !i_preset
    && !$past(i_rd) && !$past(i_wr) && !$past(i_preset)
    && $stable(i_op_activity) && $stable(i_qu_activity)
    && $past(i_op_activity, 2) == i_op_activity && $past(i_qu_activity, 2) == i_qu_activity
    |=> $stable(o_op_summary) && $stable(o_qu_summary)) else $error("general reset acted");
endmodule

// file: ser_status_regs.sv
/*
  Operation and questionable status register groups: condition, rise and
  fall filters, read-clear event latch and enable mask, plus summary bits.
  Assumes a command decoder presents one read or write per cycle by index,
  and that condition inputs are synchronous to i_clk_sys.
*/
// Notes on behaviour
// - Every register part holds 15 bits; reads and writes use 0 to 32767.
// - General instrument reset leaves all status parts unchanged.
// - Condition part mirrors hardware live; reading it changes nothing.
// - Condition bit is set exactly while its action is in progress.
// - Event part accumulates filtered transitions until software reads it.
// - Reading the event part returns its bits then clears it; a hit in the read cycle is kept.
// - Fall filter bit set: condition one to zero sets the event bit.
// - Rise filter bit set: condition zero to one sets the event bit.
// - Enable part selects which event bits feed the group summary bit.
// - Summary bits can raise a service request to the host.
// - Preset loads every rise filter with all ones.
// - Preset clears every fall filter to zero.
// - Preset clears both groups' enable parts to zero.
// - A questionable group exists with its own live condition part.
// - Writes to filters and enables replace the previous contents.
`timescale 1ns/1ps
`include "ser_consts.svh"

module ser_status_regs (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic              i_inst_reset,
  input  wire logic              i_preset,
  input  wire ser_pkg::ser_word_t i_op_activity,
  input  wire ser_pkg::ser_word_t i_qu_activity,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire ser_pkg::ser_idx_t i_idx,
  input  wire ser_pkg::ser_word_t i_wdata,
  output logic [`SER_W-1:0]      o_rdata,
  output logic                   o_rvalid,
  output logic                   o_op_summary,
  output logic                   o_qu_summary,
  output logic                   o_srq
);

  ser_pkg::ser_word_t op_cond_q, qu_cond_q;
  ser_pkg::ser_word_t op_rise_q, op_fall_q, op_ena_q, op_evt_q;
  ser_pkg::ser_word_t qu_rise_q, qu_fall_q, qu_ena_q, qu_evt_q;
  ser_pkg::ser_word_t op_hit, qu_hit;
  logic               op_evt_rd, qu_evt_rd;

  // Filtered edge detect, shared by both groups
  function automatic ser_pkg::ser_word_t edge_hits(
    input ser_pkg::ser_word_t prev,
    input ser_pkg::ser_word_t now,
    input ser_pkg::ser_word_t rise,
    input ser_pkg::ser_word_t fall
  );
    edge_hits = (~prev & now & rise)
              | (prev & ~now & fall);
  endfunction

  // Condition parts track activity; the instrument reset is not wired here
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      op_cond_q <= `SER_ZERO;
      qu_cond_q <= `SER_ZERO;
    end else begin
      op_cond_q <= i_op_activity;
      qu_cond_q <= i_qu_activity;
    end
  end

  assign op_hit    = edge_hits(op_cond_q, i_op_activity, op_rise_q, op_fall_q);
  assign qu_hit    = edge_hits(qu_cond_q, i_qu_activity, qu_rise_q, qu_fall_q);
  assign op_evt_rd = i_rd && (i_idx == `SER_IDX_OP_EVT);
  assign qu_evt_rd = i_rd && (i_idx == `SER_IDX_QU_EVT);

  // Filters and enables: i_inst_reset deliberately ignored
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      op_rise_q <= `SER_RISE_PRESET;
      qu_rise_q <= `SER_RISE_PRESET;
      op_fall_q <= `SER_FALL_PRESET;
      qu_fall_q <= `SER_FALL_PRESET;
      op_ena_q  <= `SER_ENA_PRESET;
      qu_ena_q  <= `SER_ENA_PRESET;
    end else if (i_preset) begin
      op_rise_q <= `SER_RISE_PRESET;
      qu_rise_q <= `SER_RISE_PRESET;
      op_fall_q <= `SER_FALL_PRESET;
      qu_fall_q <= `SER_FALL_PRESET;
      op_ena_q  <= `SER_ENA_PRESET;
      qu_ena_q  <= `SER_ENA_PRESET;
    end else if (i_wr) begin
      // Port is 15 bits wide, so out-of-range values cannot arrive
      unique case (i_idx)
        `SER_IDX_OP_RISE: op_rise_q <= i_wdata;
        `SER_IDX_OP_FALL: op_fall_q <= i_wdata;
        `SER_IDX_OP_ENA:  op_ena_q  <= i_wdata;
        `SER_IDX_QU_RISE: qu_rise_q <= i_wdata;
        `SER_IDX_QU_FALL: qu_fall_q <= i_wdata;
        `SER_IDX_QU_ENA:  qu_ena_q  <= i_wdata;
        default: ;
      endcase
    end
  end

  // Event latches; a new hit ORs in after the read clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      op_evt_q <= `SER_ZERO;
      qu_evt_q <= `SER_ZERO;
    end else begin
      op_evt_q <= (op_evt_rd ? `SER_ZERO : op_evt_q) | op_hit;
      qu_evt_q <= (qu_evt_rd ? `SER_ZERO : qu_evt_q) | qu_hit;
    end
  end

  // Read data registered, one cycle after the request
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata  <= `SER_ZERO;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        unique case (i_idx)
          `SER_IDX_OP_COND: o_rdata <= op_cond_q;
          `SER_IDX_OP_ENA:  o_rdata <= op_ena_q;
          `SER_IDX_OP_EVT:  o_rdata <= op_evt_q;
          `SER_IDX_OP_FALL: o_rdata <= op_fall_q;
          `SER_IDX_OP_RISE: o_rdata <= op_rise_q;
          `SER_IDX_QU_COND: o_rdata <= qu_cond_q;
          `SER_IDX_QU_ENA:  o_rdata <= qu_ena_q;
          `SER_IDX_QU_EVT:  o_rdata <= qu_evt_q;
          `SER_IDX_QU_FALL: o_rdata <= qu_fall_q;
          `SER_IDX_QU_RISE: o_rdata <= qu_rise_q;
          default:          o_rdata <= `SER_ZERO;
        endcase
      end
    end
  end

  // Summary bits registered so they lag the event latch by one cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_op_summary <= 1'b0;
      o_qu_summary <= 1'b0;
    end else begin
      o_op_summary <= |(op_evt_q & op_ena_q);
      o_qu_summary <= |(qu_evt_q & qu_ena_q);
    end
  end

  assign o_srq = o_op_summary | o_qu_summary;

endmodule

// file: ser_status_regs_tb.sv
/*
  Directed bench for the status register groups.
  Assumes the design and checker files are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected t=%0t got %h want %h", $time, a, b); end end
module ser_status_regs_tb;
  logic i_clk_sys, i_rst_n, i_inst_reset, i_preset, i_wr, i_rd, o_rvalid;
  logic o_op_summary, o_qu_summary, o_srq;
  ser_pkg::ser_word_t i_op_activity, i_qu_activity, i_wdata, o_rdata;
  ser_pkg::ser_idx_t  i_idx;
  int                 n_errors, checks;
  ser_status_regs uut (.i_clk_sys, .i_rst_n, .i_inst_reset, .i_preset, .i_op_activity,
    .i_qu_activity, .i_wr, .i_rd, .i_idx, .i_wdata, .o_rdata, .o_rvalid,
    .o_op_summary, .o_qu_summary, .o_srq);
  initial begin
    i_clk_sys = 0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic cyc(int n); repeat (n) @(negedge i_clk_sys); endtask
  // Trailing idle cycle keeps strobes from toggling twice in one step
  task automatic rd_chk(ser_pkg::ser_idx_t i, ser_pkg::ser_word_t e);
    i_idx = i; i_rd = 1; cyc(1); i_rd = 0;
    `CHK(o_rvalid, 1'b1)
    `CHK(o_rdata, e)
    cyc(1);
  endtask
  task automatic wr(ser_pkg::ser_idx_t i, ser_pkg::ser_word_t d);
    i_idx = i; i_wdata = d; i_wr = 1; cyc(1); i_wr = 0; cyc(1);
  endtask
  task automatic s_defaults;
    rd_chk(4'h4, 15'h7FFF); rd_chk(4'h9, 15'h7FFF);
    rd_chk(4'h3, 15'h0000); rd_chk(4'h8, 15'h0000);
    rd_chk(4'h1, 15'h0000); rd_chk(4'h6, 15'h0000);
  endtask
  task automatic s_rise;
    i_op_activity = 15'h0001; cyc(2);
    rd_chk(4'h0, 15'h0001); rd_chk(4'h0, 15'h0001);
    rd_chk(4'h2, 15'h0001); rd_chk(4'h2, 15'h0000);
  endtask
  task automatic s_fall;
    wr(4'h3, 15'h0001); wr(4'h4, 15'h0000); rd_chk(4'h4, 15'h0000);
    i_op_activity = 15'h0000; cyc(2); rd_chk(4'h2, 15'h0001);
    i_op_activity = 15'h0001; cyc(2); rd_chk(4'h2, 15'h0000);
  endtask
  task automatic s_summary;
    wr(4'h6, 15'h7FFF); i_qu_activity = 15'h4000; cyc(3);
    `CHK(o_qu_summary, 1'b1)
    `CHK(o_srq, 1'b1)
    rd_chk(4'h5, 15'h4000);
    i_inst_reset = 1; cyc(1); i_inst_reset = 0; cyc(2);
    `CHK(o_qu_summary, 1'b1)
    rd_chk(4'h3, 15'h0001);
    i_preset = 1; cyc(1); i_preset = 0; cyc(2);
    `CHK(o_srq, 1'b0)
    rd_chk(4'h4, 15'h7FFF); rd_chk(4'h3, 15'h0000); rd_chk(4'hF, 15'h0000);
  endtask
  // Rising edge lands in the same cycle as the event read
  task automatic s_clash;
    wr(4'h1, 15'h0002); wr(4'h2, 15'h7FFF);
    `CHK(o_op_summary, 1'b0)
    i_op_activity = 15'h0003; i_idx = 4'h2; i_rd = 1; cyc(1); i_rd = 0;
    `CHK(o_rdata, 15'h0000)
    cyc(1);
    `CHK(o_op_summary, 1'b1)
    rd_chk(4'h2, 15'h0002);
    `CHK(o_op_summary, 1'b0)
    `CHK(o_srq, 1'b0)
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {i_rst_n, i_inst_reset, i_preset, i_wr, i_rd} = '0;
    {i_op_activity, i_qu_activity, i_wdata, i_idx} = '0;
    cyc(20); i_rst_n = 1; cyc(1);
    s_defaults(); s_rise(); s_fall(); s_summary(); s_clash();
    final_report();
  end
endmodule
bind ser_status_regs ser_status_asserts chk (.i_clk_sys, .i_rst_n, .i_inst_reset, .i_preset,
  .i_op_activity, .i_qu_activity, .i_wr, .i_rd, .i_idx, .i_wdata, .o_rdata, .o_rvalid,
  .o_op_summary, .o_qu_summary, .o_srq);
